// *** mmd_pkg.sv ***
// Purpose: Shared constants for the memory map decoder
// Assumes: 16-bit data space, 23-bit paged program space
// Notes:   Addresses are word addresses
package mmd_pkg;
  localparam int DW = 16;
  localparam int PAW = 23;
  localparam int PGW = 7;
  localparam int BLKW = 13;
  localparam int ROMW = 14;
  localparam int NBLK = 8;
  // Memory-mapped registers in data page 0
  localparam logic [15:0] PAGE_ADDR = 16'h001e;
  localparam logic [15:0] MODE_ADDR = 16'h001d;
  localparam logic [15:0] MMR_TOP = 16'h007f;
  // Data space RAM slices
  localparam logic [15:0] LOW_RAM_LO = 16'h0080;
  localparam logic [15:0] LOW_RAM_HI = 16'h7fff;
  localparam logic [15:0] HIGH_RAM_LO = 16'h8000;
  // Program space
  localparam logic [15:0] ROM_LO = 16'hc000;
  localparam logic [PGW-1:0] ROM_PAGE = 7'h00;
  localparam logic [PGW-1:0] HIGH_RAM_PAGE = 7'h01;
  localparam logic [15:0] VEC_BASE = 16'hff80;
  // Host port read window under RAM/ROM security
  localparam logic [15:0] HP_RD_LO = 16'h4000;
  localparam logic [15:0] HP_RD_HI = 16'h5fff;
  localparam logic [15:0] BLANK_WORD = 16'hffff;
  // Mode register fields and resets
  localparam int VECTOR_PAGE_POINTER_MSB = 15;
  localparam int VECTOR_PAGE_POINTER_LSB = 7;
  localparam int ROM_MODE_BIT = 6;
  localparam int RAM_OVERLAY_ENABLE_BIT = 5;
  localparam int ADDRESS_VISIBILITY_BIT = 4;
  localparam int PROGRAM_RAM_IN_DATA_ENABLE_BIT = 3;
  localparam int CLOCK_OUTPUT_DISABLE_BIT = 2;
  localparam int MULTIPLY_SATURATION_BIT = 1;
  localparam int SST_BIT = 0;
  localparam logic [8:0] VECTOR_PAGE_POINTER_RST = 9'h1ff;
  localparam logic [5:0] LOW_BITS_RST = 6'h00;
  localparam logic [15:0] PAGE_RST = 16'h0000;
endpackage : mmd_pkg

// *** mmd_range.sv ***
// Purpose: Inclusive address window compare for one RAM slice
// Assumes: LO not above HI
// Notes:   Pure combinational, no state
module mmd_range #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hffff
) (
  input  wire logic [15:0] addr,
  output logic             hit
);
  assign hit = (addr >= LO) && (addr <= HI);
endmodule : mmd_range

// *** mmd_decode.sv ***
// Purpose: Program/data/host address decode and memory security
// Assumes: Requests synchronous to mclk; decode answered next edge, host port grants in the same cycle
// Notes:   Security option straps are static mask inputs

// Function
// RQ1 - Data space 64K; outside RAM goes external
// RQ2 - Unmapped program addresses go external
// RQ3 - 128 pages of 64K via page register
// RQ4 - Page register at data 001Eh, reset zero
// RQ5 - 16K ROM exists only in program space
// RQ6 - ROM at C000h-FFFFh, vectors FF80h
// RQ7 - Software leaves FF00h-FF7Fh unused
// RQ8 - Rom mode low starts at FF80h
// RQ9 - Eight 8K dual-access RAM blocks
// RQ10 - Low four blocks; overlay maps to program
// RQ11 - High four blocks; data-ROM maps to data
// RQ12 - Data slices of 8K per block
// RQ13 - Program slices 018000h-01FFFFh in order
// RQ14 - Secure ROM reads from outside return FFFFh
// RQ15 - Security blocks emulation, keeps boundary scan
// RQ16 - RAM/ROM security forces rom mode zero
// RQ17 - RAM/ROM security limits host reads 4000h-5FFFh
// RQ18 - ROM-only: host free, mode from pin
// RQ19 - Taken vector loads PC, four words each
// RQ20 - Vectors at page given by pointer
// RQ21 - Hardware reset sets pointer all ones
// RQ22 - Mode register layout and resets
// RQ23 - Overlay never maps addresses 0h-7Fh
// RQ24 - Rom mode bit enables ROM; pin at reset
// RQ25 - Software reset keeps vector pointer
// RQ26 - Exactly one program target per access
module mmd_decode (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire logic                    soft_rst,
  input  wire logic                    rom_mode_select,
  input  wire logic                    sec_ram_rom,
  input  wire logic                    sec_rom_only,
  // Program address generator
  input  wire logic                    prog_req,
  input  wire logic                    prog_fetch,
  input  wire logic [15:0]             prog_addr,
  output logic                         prog_sel_rom,
  output logic [3:0]                   prog_sel_ram,
  output logic                         prog_sel_ext,
  output logic [mmd_pkg::PAW-1:0]      prog_ext_addr,
  output logic [mmd_pkg::ROMW-1:0]     prog_rom_addr,
  output logic [mmd_pkg::BLKW-1:0]     prog_ram_addr,
  input  wire logic [15:0]             rom_rdata,
  output logic [15:0]                  prog_rdata,
  output logic                         prog_rdata_valid,
  // Data address generator
  input  wire logic                    data_rd,
  input  wire logic                    data_wr,
  input  wire logic [15:0]             data_addr,
  input  wire logic [15:0]             data_wdata,
  output logic [mmd_pkg::NBLK-1:0]     data_sel_ram,
  output logic                         data_sel_ext,
  output logic                         data_sel_mmr,
  output logic [mmd_pkg::BLKW-1:0]     data_ram_addr,
  output logic [15:0]                  data_reg_rdata,
  // Host port
  input  wire logic                    hp_rd,
  input  wire logic                    hp_wr,
  input  wire logic [15:0]             hp_addr,
  output logic                         hp_rd_grant,
  output logic                         hp_wr_grant,
  // Vectors
  input  wire logic                    vec_take,
  input  wire logic [4:0]              vec_num,
  output logic [15:0]                  vec_pc,
  output logic                         vec_load,
  // Emulation and mode outputs
  input  wire logic                    emu_req,
  output logic                         emu_grant,
  output logic                         bscan_enable,
  output logic [15:0]                  mode_reg,
  output logic [15:0]                  page_reg
);

  logic [8:0]  vector_page_pointer;
  logic        rom_mode;
  logic [5:0]  low_bits;
  logic        ram_overlay_enable;
  logic        program_ram_in_data_enable;
  logic        secure;
  logic        exec_rom;
  logic        rom_pending;
  logic        blank_pending;
  logic [mmd_pkg::PGW-1:0] page;
  logic [mmd_pkg::NBLK-1:0] blk_hit;
  logic        p_rom;
  logic [3:0]  p_ram;
  logic        p_ext;

  assign ram_overlay_enable   = low_bits[mmd_pkg::RAM_OVERLAY_ENABLE_BIT];
  assign program_ram_in_data_enable   = low_bits[mmd_pkg::PROGRAM_RAM_IN_DATA_ENABLE_BIT];
  assign secure = sec_ram_rom | sec_rom_only;
  assign page   = page_reg[mmd_pkg::PGW-1:0];
  assign mode_reg = {vector_page_pointer, rom_mode, low_bits}; // see RQ22

  // Mode register: pointer, rom mode and six plain bits
  always_ff @(posedge mclk) begin
    if (rst) begin
      vector_page_pointer <= mmd_pkg::VECTOR_PAGE_POINTER_RST; // see RQ21
    end else if (ce && data_wr && data_addr == mmd_pkg::MODE_ADDR) begin
      vector_page_pointer <= data_wdata[mmd_pkg::VECTOR_PAGE_POINTER_MSB:mmd_pkg::VECTOR_PAGE_POINTER_LSB]; // see RQ20
    end
    // Software reset leaves the pointer alone
  end // see RQ25

  // Strap is sampled only while reset is held; sync reset makes this legal
  always_ff @(posedge mclk) begin
    if (rst) begin
      rom_mode <= sec_ram_rom ? 1'b0 : rom_mode_select; // see RQ16 RQ18
    end else if (ce && data_wr && data_addr == mmd_pkg::MODE_ADDR) begin
      rom_mode <= data_wdata[mmd_pkg::ROM_MODE_BIT]; // see RQ24
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      low_bits <= mmd_pkg::LOW_BITS_RST; // see RQ22
    end else if (ce) begin
      if (data_wr && data_addr == mmd_pkg::MODE_ADDR) begin
        low_bits <= data_wdata[5:0];
      end else if (soft_rst) begin
        low_bits <= mmd_pkg::LOW_BITS_RST;
      end
    end
  end

  // Program page register
  always_ff @(posedge mclk) begin
    if (rst) begin
      page_reg <= mmd_pkg::PAGE_RST; // see RQ4
    end else if (ce && data_wr && data_addr == mmd_pkg::PAGE_ADDR) begin
      page_reg <= {9'h000, data_wdata[mmd_pkg::PGW-1:0]}; // see RQ3
    end
  end

  // Data space block windows, one per RAM block
  genvar gi;
  generate
    for (gi = 0; gi < mmd_pkg::NBLK; gi++) begin : g_blk
      localparam logic [15:0] BASE = 16'(gi * 16'h2000);
      localparam logic [15:0] LO =
        (gi == 0) ? mmd_pkg::LOW_RAM_LO : BASE;
      mmd_range #(
        .LO (LO),
        .HI (16'(BASE + 16'h1fff))
      ) u_rng (
        .addr (data_addr),
        .hit  (blk_hit[gi])
      ); // see RQ9 RQ12
    end
  endgenerate

  // Program space target, ROM wins over any other on-chip hit
  always_comb begin
    p_rom = 1'b0;
    p_ram = 4'h0;
    p_ext = 1'b0;
    if (page == mmd_pkg::ROM_PAGE && !rom_mode &&
        prog_addr >= mmd_pkg::ROM_LO) begin
      p_rom = 1'b1; // see RQ5 RQ6 RQ24
    end else if (ram_overlay_enable && prog_addr >= mmd_pkg::LOW_RAM_LO &&
                 prog_addr <= mmd_pkg::LOW_RAM_HI) begin
      p_ram[prog_addr[14:13]] = 1'b1; // see RQ10 RQ23
    end else if (page == mmd_pkg::HIGH_RAM_PAGE &&
                 prog_addr >= mmd_pkg::HIGH_RAM_LO) begin
      p_ram[prog_addr[14:13]] = 1'b1; // see RQ11 RQ13
    end else begin
      p_ext = 1'b1; // see RQ2
    end
  end // see RQ26

  // Program decode outputs, one cycle after the request
  always_ff @(posedge mclk) begin
    if (rst) begin
      prog_sel_rom  <= 1'b0;
      prog_sel_ram  <= 4'h0;
      prog_sel_ext  <= 1'b0;
      prog_ext_addr <= '0;
      prog_rom_addr <= '0;
      prog_ram_addr <= '0;
    end else if (ce) begin
      prog_sel_rom  <= prog_req & p_rom;
      prog_sel_ram  <= prog_req ? p_ram : 4'h0;
      prog_sel_ext  <= prog_req & p_ext;
      prog_ext_addr <= {page, prog_addr}; // see RQ3
      prog_rom_addr <= prog_addr[mmd_pkg::ROMW-1:0];
      prog_ram_addr <= prog_addr[mmd_pkg::BLKW-1:0];
    end
  end

  // Tracks where the executing instruction came from
  always_ff @(posedge mclk) begin
    if (rst) begin
      exec_rom <= 1'b1;
    end else if (ce && prog_req && prog_fetch) begin
      exec_rom <= p_rom;
    end
  end

  // A fetch into ROM is always allowed, so branches into ROM still work
  always_ff @(posedge mclk) begin
    if (rst) begin
      rom_pending   <= 1'b0;
      blank_pending <= 1'b0;
    end else if (ce) begin
      rom_pending   <= prog_req & p_rom;
      blank_pending <= prog_req & p_rom & !prog_fetch &
                       secure & !exec_rom; // see RQ14
    end
  end

  // ROM word returned two cycles after the request
  always_ff @(posedge mclk) begin
    if (rst) begin
      prog_rdata       <= 16'h0000;
      prog_rdata_valid <= 1'b0;
    end else if (ce) begin
      prog_rdata_valid <= rom_pending;
      if (rom_pending) begin
        prog_rdata <= blank_pending ? mmd_pkg::BLANK_WORD
                                    : rom_data_in(rom_rdata); // see RQ14
      end
    end
  end

  function automatic logic [15:0] rom_data_in(input logic [15:0] d);
    rom_data_in = d;
  endfunction : rom_data_in

  // Data decode; page 0 never reaches RAM
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_sel_ram  <= '0;
      data_sel_ext  <= 1'b0;
      data_sel_mmr  <= 1'b0;
      data_ram_addr <= '0;
    end else if (ce) begin
      data_ram_addr <= data_addr[mmd_pkg::BLKW-1:0];
      data_sel_ram  <= '0;
      data_sel_ext  <= 1'b0;
      data_sel_mmr  <= 1'b0;
      if (data_rd || data_wr) begin
        if (data_addr <= mmd_pkg::MMR_TOP) begin
          data_sel_mmr <= 1'b1;
        end else if (data_addr <= mmd_pkg::LOW_RAM_HI) begin
          data_sel_ram <= blk_hit; // see RQ1 RQ10
        end else if (program_ram_in_data_enable) begin
          data_sel_ram <= blk_hit; // see RQ11
        end else begin
          data_sel_ext <= 1'b1; // see RQ1
        end
      end
    end
  end

  // Register read data
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_reg_rdata <= 16'h0000;
    end else if (ce && data_rd) begin
      if (data_addr == mmd_pkg::PAGE_ADDR) begin
        data_reg_rdata <= page_reg;
      end else if (data_addr == mmd_pkg::MODE_ADDR) begin
        data_reg_rdata <= mode_reg;
      end else begin
        data_reg_rdata <= 16'h0000;
      end
    end
  end

  // Host port gating is combinational so it can stall the host at once
  assign hp_wr_grant = hp_wr; // see RQ17 RQ18
  assign hp_rd_grant = hp_rd &&
    (!sec_ram_rom || (hp_addr >= mmd_pkg::HP_RD_LO &&
                      hp_addr <= mmd_pkg::HP_RD_HI)); // see RQ17

  // Vector fetch address: pointer page plus four words per vector
  always_ff @(posedge mclk) begin
    if (rst) begin
      vec_pc   <= mmd_pkg::VEC_BASE; // see RQ8 RQ21
      vec_load <= 1'b0;
    end else if (ce) begin
      vec_load <= vec_take;
      if (vec_take) begin
        vec_pc <= {vector_page_pointer, vec_num, 2'b00}; // see RQ19 RQ20
      end
    end
  end

  // Emulation is refused outright on a secured part
  assign emu_grant    = emu_req & !secure; // see RQ15
  assign bscan_enable = 1'b1; // see RQ15

endmodule : mmd_decode

// *** mmd_rom_model.sv ***
// Purpose: Behavioural mask ROM array facing the decoder
// Assumes: Word is answered in the cycle its select is high
// Notes:   Word content is {2'b10, address} so every location differs
module mmd_rom_model (
  input  logic        prog_sel_rom,
  input  logic [13:0] prog_rom_addr,
  output logic [15:0] rom_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Unselected array shows the inverse so a stale word never matches
  // Content keeps FF00h-FF7Fh as plain filler, no code there
  assign rom_rdata = prog_sel_rom ? {2'b10, prog_rom_addr}
                                  : ~{2'b10, prog_rom_addr};
endmodule : mmd_rom_model

// *** mmd_monitor.sv ***
// Purpose: Port-level checker for the memory map decoder
// Assumes: Single clock domain, sync active-high reset
// Notes:   Attached by bind below
module mmd_monitor (
  input logic        mclk,
  input logic        rst,
  input logic        ce,
  input logic        data_rd,
  input logic        data_wr,
  input logic [15:0] data_addr,
  input logic [15:0] data_wdata,
  input logic [7:0]  data_sel_ram,
  input logic        prog_req,
  input logic        prog_fetch,
  input logic [15:0] prog_addr,
  input logic        prog_sel_rom,
  input logic [3:0]  prog_sel_ram,
  input logic        prog_sel_ext,
  input logic        prog_rdata_valid,
  input logic        vec_take,
  input logic [4:0]  vec_num,
  input logic [15:0] vec_pc,
  input logic        vec_load,
  input logic        sec_ram_rom,
  input logic        sec_rom_only,
  input logic        emu_grant,
  input logic        bscan_enable,
  input logic        hp_rd,
  input logic [15:0] hp_addr,
  input logic        hp_rd_grant,
  input logic [15:0] mode_reg,
  input logic [15:0] page_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence rom_fetch_s;
    prog_req && ce && prog_fetch && prog_addr >= 16'hc000 &&
    !mode_reg[6] && page_reg[6:0] == 7'h00;
  endsequence
  sequence rom_answer_s;
    prog_sel_rom ##1 prog_rdata_valid;
  endsequence
  page_write_a: assert property (data_wr && ce && data_addr == 16'h001e
    |=> page_reg == {9'h000, $past(data_wdata[6:0])}) else $error("page");
  low_slice_a: assert property (data_rd && ce && data_addr >= 16'h0080 &&
    data_addr <= 16'h1fff |=> data_sel_ram == 8'h01) else $error("slice");
  one_target_a: assert property ($onehot0({prog_sel_rom, prog_sel_ram,
    prog_sel_ext})) else $error("targets");
  vec_place_a: assert property (vec_take && ce |=> vec_load &&
    vec_pc == {$past(mode_reg[15:7]), $past(vec_num), 2'b00}) else $error("vec");
  sec_mode_a: assert property ($past(rst) && sec_ram_rom
    |-> !mode_reg[6]) else $error("secmode");
  emu_block_a: assert property (sec_ram_rom || sec_rom_only
    |-> !emu_grant && bscan_enable) else $error("emu");
  host_read_a: assert property (sec_ram_rom && hp_rd && (hp_addr < 16'h4000
    || hp_addr > 16'h5fff) |-> !hp_rd_grant) else $error("host");
  rom_fetch_a: assert property (rom_fetch_s |=> rom_answer_s)
    else $error("rom");
  page_zero_a: assert property (prog_req && ce && prog_addr <= 16'h007f
    |=> prog_sel_ext) else $error("low");
endmodule : mmd_monitor
bind mmd_decode mmd_monitor i_mon (.*);

// *** mmd_tb.sv ***
// Purpose: Directed bench for the memory map decoder
// Assumes: Inputs change at falling edge, decode answers one edge later, ROM data two, host grants at once
// Notes:   ROM array comes from mmd_rom_model
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("Error %s exp %h got %h", n, e, g); err_total++; end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, ce, soft_rst, rom_mode_select, sec_ram_rom, sec_rom_only;
  logic prog_req, prog_fetch, prog_sel_rom, prog_sel_ext, prog_rdata_valid;
  logic [15:0] prog_addr, rom_rdata, prog_rdata, data_addr, data_wdata;
  logic [3:0] prog_sel_ram;
  logic [22:0] prog_ext_addr;
  logic [13:0] prog_rom_addr;
  logic [12:0] prog_ram_addr, data_ram_addr;
  logic data_rd, data_wr, data_sel_ext, data_sel_mmr, hp_rd, hp_wr;
  logic [7:0] data_sel_ram;
  logic [15:0] data_reg_rdata, hp_addr, vec_pc, mode_reg, page_reg;
  logic hp_rd_grant, hp_wr_grant, vec_take, vec_load, emu_req, emu_grant;
  logic bscan_enable;
  logic [4:0] vec_num;
  int err_total, n_checks, cyc;
  mmd_decode i_dut (.*);
  mmd_rom_model i_rom (.prog_sel_rom(prog_sel_rom),
    .prog_rom_addr(prog_rom_addr), .rom_rdata(rom_rdata));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic hw_reset(input logic pin, rr, ro);
    @(negedge mclk); rst = 1; rom_mode_select = pin;
    sec_ram_rom = rr; sec_rom_only = ro;
    repeat (4) @(negedge mclk);
    rst = 0;
  endtask : hw_reset
  task automatic dwr(input logic [15:0] a, d);
    @(negedge mclk); data_wr = 1; data_addr = a; data_wdata = d;
    @(negedge mclk); data_wr = 0;
  endtask : dwr
  task automatic drd(input logic [15:0] a);
    @(negedge mclk); data_rd = 1; data_addr = a;
    @(negedge mclk); data_rd = 0;
  endtask : drd
  task automatic prq(input logic [15:0] a, input logic f);
    @(negedge mclk); prog_req = 1; prog_addr = a; prog_fetch = f;
    @(negedge mclk); prog_req = 0;
  endtask : prq
  task automatic hp(input logic r, w, input logic [15:0] a);
    @(negedge mclk); hp_rd = r; hp_wr = w; hp_addr = a; #1;
  endtask : hp
  task automatic t_reset;
    hw_reset(1, 0, 0);
    rom_mode_select = 0; drd(16'h0100);
    `CHK("mode", 16'hffc0, mode_reg)
    hw_reset(0, 0, 0);
    `CHK("mode", 16'hff80, mode_reg)
    `CHK("page", 16'h0000, page_reg)
    `CHK("vpc", 16'hff80, vec_pc)
  endtask : t_reset
  task automatic t_page;
    dwr(16'h001e, 16'hff05); `CHK("page", 16'h0005, page_reg)
    prq(16'h1234, 1); `CHK("ext", 1'b1, prog_sel_ext)
    `CHK("xa", {7'h05, 16'h1234}, prog_ext_addr)
    drd(16'h001e); `CHK("mmr", 1'b1, data_sel_mmr)
    `CHK("rd", 16'h0005, data_reg_rdata)
    dwr(16'h001e, 16'h0000);
  endtask : t_page
  task automatic t_data;
    dwr(mmd_pkg::MODE_ADDR, 16'hff88);
    for (int b = 0; b < 8; b++) begin
      drd(16'(b * 16'h2000 + 16'h0100));
      `CHK("dsel", 8'(1 << b), data_sel_ram)
      `CHK("dra", 13'h0100, data_ram_addr)
    end
    dwr(mmd_pkg::MODE_ADDR, 16'hff80);
    drd(16'h8000); `CHK("dext", 1'b1, data_sel_ext)
    drd(16'hc000); `CHK("program_ram_in_data_enable", 8'h00, data_sel_ram)
  endtask : t_data
  task automatic t_prog;
    prq(16'hc000, 1); `CHK("rom", 14'h0000, prog_rom_addr)
    @(negedge mclk); `CHK("prd", 16'h8000, prog_rdata)
    `CHK("pval", 1'b1, prog_rdata_valid)
    prq(16'hff80, 1); `CHK("vrom", 14'h3f80, prog_rom_addr)
    dwr(mmd_pkg::MODE_ADDR, 16'hffa0);
    prq(16'h0100, 1); `CHK("ovl", 4'b0001, prog_sel_ram)
    `CHK("pra", 13'h0100, prog_ram_addr)
    prq(16'h0040, 1); `CHK("p0", 1'b1, prog_sel_ext)
    prq(16'hc000, 1); `CHK("one", 4'b0000, prog_sel_ram)
    `CHK("onerom", 1'b1, prog_sel_rom)
    dwr(mmd_pkg::MODE_ADDR, 16'hff80); dwr(16'h001e, 16'h0001);
    prq(16'he000, 1); `CHK("hi", 4'b1000, prog_sel_ram)
    `CHK("hra", 13'h0000, prog_ram_addr)
    dwr(16'h001e, 16'h0000); dwr(mmd_pkg::MODE_ADDR, 16'hffc0);
    prq(16'hc000, 1); `CHK("nrom", 1'b1, prog_sel_ext)
  endtask : t_prog
  task automatic t_vec;
    @(negedge mclk); vec_take = 1; vec_num = 5'd3;
    @(negedge mclk); vec_take = 0; `CHK("vpc", 16'hff8c, vec_pc)
    `CHK("vld", 1'b1, vec_load)
    dwr(mmd_pkg::MODE_ADDR, 16'h00ff);
    @(negedge mclk); vec_take = 1; vec_num = 5'h1f;
    @(negedge mclk); vec_take = 0; `CHK("vpc", 16'h00fc, vec_pc)
    @(negedge mclk); soft_rst = 1;
    @(negedge mclk); soft_rst = 0; `CHK("soft", 16'h00c0, mode_reg)
  endtask : t_vec
  task automatic t_secure;
    hw_reset(1, 1, 0); `CHK("smode", 16'hff80, mode_reg)
    emu_req = 1; #1; `CHK("emu", 1'b0, emu_grant)
    hp(1, 0, 16'h5fff); `CHK("hr", 1'b1, hp_rd_grant)
    hp(1, 0, 16'h6000); `CHK("hr", 1'b0, hp_rd_grant)
    hp(0, 1, 16'h6000); `CHK("hw", 1'b1, hp_wr_grant)
    prq(16'h1234, 1); prq(16'hc000, 0);
    @(negedge mclk); `CHK("blank", 16'hffff, prog_rdata)
    prq(16'hc000, 1); prq(16'hc001, 0);
    @(negedge mclk); `CHK("own", 16'h8001, prog_rdata)
    hw_reset(1, 0, 1); `CHK("omode", 16'hffc0, mode_reg)
    hp(1, 0, 16'h6000); `CHK("hr", 1'b1, hp_rd_grant)
    `CHK("bs", 1'b1, bscan_enable)
  endtask : t_secure
  initial begin
    rst = 1'b1;
    {soft_rst, rom_mode_select, sec_ram_rom, sec_rom_only} = '0;
    {prog_req, prog_fetch, data_rd, data_wr, hp_rd, hp_wr} = '0;
    {vec_take, emu_req, vec_num, prog_addr, data_addr} = '0;
    {data_wdata, hp_addr} = '0;
    ce = 1;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    t_reset(); t_page(); t_data(); t_prog(); t_vec(); t_secure();
    tally_and_finish();
  end
endmodule : testbench
